//--- host_model.sv
/*
 * behavioural host command engine for the temperature fault block:
 * issues single-byte reads and writes and clear-faults pulses.
 * assumes the block answers on the same edge that takes a command.
 */
`timescale 1ns/10ps

module host_model
	import temp_fault_pkg::*;
(
	input wire logic clock_in,
	input wire logic [7:0] read_data_in,
	input wire logic read_valid_in,
	input wire logic write_refused_in,
	output cmd_req_t cmd_out,
	output logic clear_out
);

	// ------------------------------------------------------------------
	// command transfers
	// ------------------------------------------------------------------
	initial begin
		cmd_out = '0;
		clear_out = 1'b0;
	end

	// idle fields are inverted so a stale byte never passes as fresh
	task automatic transfer(input logic wr, input logic rd,
		input logic page, input logic [7:0] code, input logic [7:0] data,
		output logic [7:0] rdata, output logic valid, output logic refused);
		@(posedge clock_in);
		cmd_out <= '{wr: wr, rd: rd, page: page, code: code, data: data};
		@(posedge clock_in);
		cmd_out <= '{wr: 1'b0, rd: 1'b0, page: ~page, code: ~code,
			data: ~data};
		#1;
		rdata = read_data_in;
		valid = read_valid_in;
		refused = write_refused_in;
	endtask : transfer

	// one-cycle clear-faults command
	task automatic clear_faults();
		@(posedge clock_in);
		clear_out <= 1'b1;
		@(posedge clock_in);
		clear_out <= 1'b0;
	endtask : clear_faults

endmodule : host_model

//--- response_channel.sv
/*
 * per-output response sequencer: latches the external temperature
 * flags and shuts down, holds off or retries the output.
 * assumes fault inputs are synchronous and ut_in is already sampled.
 */
`timescale 1ns/10ps
`include "temp_fault_consts.svh"

module response_channel
	import temp_fault_pkg::*;
#(
	parameter int RESTART_CYCLES = `RESTART_CYCLES
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic run_in,
	input wire logic run_rise_in,
	input wire logic clear_in,
	input wire logic ot_in,
	input wire logic ut_in,
	input wire resp_byte_t ot_resp_in,
	input wire resp_byte_t ut_resp_in,
	output logic enable_out,
	output logic ot_flag_out,
	output logic ut_flag_out
);
	localparam int CW = $clog2(RESTART_CYCLES + 1);

	chan_state_t state_r;
	logic [CW-1:0] wait_r;
	logic ot_trip;
	logic ut_trip;
	logic retry_forever;

	// ------------------------------------------------------------------
	// trip decode
	// ------------------------------------------------------------------
	// response 00 only flags; shutdown codes cut the output
	assign ot_trip = ot_in && (ot_resp_in.resp == `RESP_SHUTDOWN); // RL16
	assign ut_trip = ut_in && (ut_resp_in.resp == `RESP_SHUTDOWN);
	assign retry_forever = ot_trip ? (ot_resp_in.retry == `RETRY_FOREVER) :
		(ut_resp_in.retry == `RETRY_FOREVER);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	// commanding off ends any hold or retry, so a run cycle restarts clean
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state_r <= CH_RUN;
			wait_r <= '0;
		end else if (!run_in) begin
			state_r <= CH_RUN; // RL17
			wait_r <= '0;
		end else begin
			case (state_r)
			CH_RUN: begin
				if (ot_trip || ut_trip) begin
					if (retry_forever) begin
						state_r <= CH_WAIT; // RL17
						wait_r <= CW'(RESTART_CYCLES - 1);
					end else begin
						state_r <= CH_HELD;
					end
				end
			end
			CH_HELD: begin
				if (clear_in)
					state_r <= CH_RUN;
			end
			CH_WAIT: begin
				if (wait_r == '0)
					state_r <= CH_RUN; // RL17
				else
					wait_r <= wait_r - 1'b1;
			end
			default: state_r <= CH_RUN;
			endcase
		end
	end

	// output cut in the very cycle of the trip
	assign enable_out = run_in && (state_r == CH_RUN) && !ot_trip && !ut_trip;

	// ------------------------------------------------------------------
	// sticky flags, a fault in the clearing cycle wins
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			ot_flag_out <= 1'b0;
		else
			ot_flag_out <= ot_in || (ot_flag_out && !(clear_in || run_rise_in)); // RL12
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			ut_flag_out <= 1'b0;
		else
			ut_flag_out <= ut_in || (ut_flag_out && !(clear_in || run_rise_in)); // RL13
	end

endmodule : response_channel

//--- temp_fault_consts.svh
/*
 * constants for the temperature fault-response block: command codes,
 * reset values, field codes, status bit positions and timing counts.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef TEMP_FAULT_CONSTS_SVH
`define TEMP_FAULT_CONSTS_SVH

// ----------------------------------------------------------------------
// command codes of the response bytes
// ----------------------------------------------------------------------
`define CMD_EXT_OT_RESP 8'h50
`define CMD_EXT_UT_RESP 8'h54
`define CMD_DIE_OT_RESP 8'hd6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EXT_RESP_RESET 8'hb8
`define DIE_RESP_RESET 8'hc0

// ----------------------------------------------------------------------
// response and retry field codes
// ----------------------------------------------------------------------
`define RESP_IGNORE 2'h0
`define RESP_BAD 2'h1
`define RESP_SHUTDOWN 2'h2
`define RESP_RESERVED 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define SB_NONE_ABOVE 0
`define SB_CML 1
`define SB_TEMPERATURE 2
`define SW_MFR 4
`define MFR_OT_BIT 5
`define ST_OT_FAULT 7
`define ST_UT_FAULT 4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define RESTART_INTERVAL_US 1000
`define RESTART_CYCLES ((`RESTART_INTERVAL_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- temp_fault_pkg.sv
/*
 * types shared by the temperature fault-response block.
 * assumes temp_fault_consts.svh holds every number.
 */
package temp_fault_pkg;

	// one response byte: action, retry policy, delay (unused)
	typedef struct packed {
		logic [1:0] resp;
		logic [2:0] retry;
		logic [2:0] delay;
	} resp_byte_t;

	// one single-byte command from the host engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic page;
		logic [7:0] code;
		logic [7:0] data;
	} cmd_req_t;

	// alert source masks, high masks the source
	typedef struct packed {
		logic die_ot;
		logic ext_ot;
		logic ext_ut;
	} alert_mask_t;

	typedef enum {CH_RUN, CH_HELD, CH_WAIT} chan_state_t;

endpackage : temp_fault_pkg

//--- temperature_fault_response.sv
/*
 * temperature fault-response logic of a dual-output controller: three
 * response bytes, status flags, alert and output enables.
 * assumes a host command engine delivering one byte per transfer on
 * cmd_in, synchronous fault levels and an adc update strobe.
 */
`timescale 1ns/10ps
`include "temp_fault_consts.svh"

// Functional notes
// (RL1) die overtemp sets catch-all, mfr, mfr-ot flags
// (RL2) every fault flags and alerts unless masked; the code raises no alert on a cml fault
// (RL3) die response codes 00, 01 refused, cml
// (RL4) die response 10 disables output at once
// (RL5) output held off while die overtemp persists
// (RL6) flags clear on clear-faults or run off-on
// (RL7) die retry 000: no restart attempts
// (RL8) die retry 001-111 refused, cml fault
// (RL9) die delay field ignored
// (RL10) external overtemp response byte, 0x50, reset 0xb8
// (RL11) external undertemp response byte, 0x54, reset 0xb8
// (RL12) external overtemp sets temperature and ot flags
// (RL13) external undertemp sets temperature and ut flags
// (RL14) undertemp sampled on each adc conversion
// (RL15) one data byte per response command
// (RL16) external response 00 keeps running, still flags
// (RL17) retry 111 restarts forever at interval
// (RL18) paged bytes: one copy per output
module temperature_fault_response
	import temp_fault_pkg::*;
#(
	parameter int RESTART_CYCLES = `RESTART_CYCLES
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire cmd_req_t cmd_in,
	input wire logic clear_faults_in,
	input wire logic [1:0] run_in,
	input wire logic die_ot_in,
	input wire logic [1:0] ext_ot_in,
	input wire logic [1:0] ext_ut_in,
	input wire logic adc_sample_in,
	input wire alert_mask_t alert_mask_in,
	output logic [7:0] read_data_out,
	output logic read_valid_out,
	output logic write_refused_out,
	output logic [7:0] status_byte_out,
	output logic [7:0] status_word_hi_out,
	output logic [7:0] mfr_status_out,
	output logic [1:0][7:0] status_temp_out,
	output logic alert_n_out,
	output logic [1:0] out_enable_out
);
	localparam int NCH = 2;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	generate
		if (RESTART_CYCLES < 1) begin : g_bad_restart
			$error("RESTART_CYCLES must be at least one");
		end
	endgenerate

	resp_byte_t die_resp_r;
	resp_byte_t ext_ot_resp_r [NCH];
	resp_byte_t ext_ut_resp_r [NCH];
	resp_byte_t wr_byte;
	logic die_wr;
	logic ext_ot_wr;
	logic ext_ut_wr;
	logic die_bad;
	logic ext_bad;
	logic cml_r;
	logic die_flag_r;
	logic [NCH-1:0] run_prev_r;
	logic [NCH-1:0] run_rise;
	logic [NCH-1:0] ut_seen_r;
	logic [NCH-1:0] ch_enable;
	logic [NCH-1:0] ch_ot_flag;
	logic [NCH-1:0] ch_ut_flag;
	logic die_hold;
	logic run_cycled;
	logic alert_set;

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	// the engine hands over exactly one data byte per command
	assign wr_byte = resp_byte_t'(cmd_in.data); // RL15
	assign die_wr = cmd_in.wr && (cmd_in.code == `CMD_DIE_OT_RESP);
	assign ext_ot_wr = cmd_in.wr && (cmd_in.code == `CMD_EXT_OT_RESP);
	assign ext_ut_wr = cmd_in.wr && (cmd_in.code == `CMD_EXT_UT_RESP);
	// only response codes 10 and 11 with no retry are served on the die byte
	assign die_bad = (wr_byte.resp == `RESP_IGNORE) || // RL3
		(wr_byte.resp == `RESP_BAD) ||
		(wr_byte.retry != `RETRY_NONE); // RL8
	assign ext_bad = (wr_byte.resp == `RESP_BAD) ||
		(wr_byte.resp == `RESP_RESERVED);

	// ------------------------------------------------------------------
	// die overtemp response byte
	// ------------------------------------------------------------------
	// delay bits are stored for read-back but steer nothing
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			die_resp_r <= resp_byte_t'(`DIE_RESP_RESET);
		else if (die_wr && !die_bad)
			die_resp_r <= wr_byte; // RL9
	end

	// ------------------------------------------------------------------
	// paged external response bytes, one copy per output
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < NCH; i++) begin
				ext_ot_resp_r[i] <= resp_byte_t'(`EXT_RESP_RESET); // RL10
				ext_ut_resp_r[i] <= resp_byte_t'(`EXT_RESP_RESET); // RL11
			end
		end else if (!ext_bad) begin
			if (ext_ot_wr)
				ext_ot_resp_r[cmd_in.page] <= wr_byte; // RL18
			if (ext_ut_wr)
				ext_ut_resp_r[cmd_in.page] <= wr_byte; // RL18
		end
	end

	// ------------------------------------------------------------------
	// communication fault, sticky until clear-faults
	// ------------------------------------------------------------------
	// a refused write in the clearing cycle still leaves the flag set
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			cml_r <= 1'b0;
		else if ((die_wr && die_bad) || ((ext_ot_wr || ext_ut_wr) && ext_bad))
			cml_r <= 1'b1; // RL3 RL8
		else if (clear_faults_in)
			cml_r <= 1'b0;
	end

	// one-cycle refusal pulse for the command engine
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			write_refused_out <= 1'b0;
		else
			write_refused_out <= (die_wr && die_bad) ||
				((ext_ot_wr || ext_ut_wr) && ext_bad);
	end

	// ------------------------------------------------------------------
	// read-back, one byte, one cycle after the request
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			read_data_out <= 8'h00;
			read_valid_out <= 1'b0;
		end else begin
			read_valid_out <= 1'b0;
			read_data_out <= 8'h00;
			if (cmd_in.rd) begin
				if (cmd_in.code == `CMD_DIE_OT_RESP) begin
					read_data_out <= die_resp_r;
					read_valid_out <= 1'b1;
				end else if (cmd_in.code == `CMD_EXT_OT_RESP) begin
					read_data_out <= ext_ot_resp_r[cmd_in.page]; // RL18
					read_valid_out <= 1'b1;
				end else if (cmd_in.code == `CMD_EXT_UT_RESP) begin
					read_data_out <= ext_ut_resp_r[cmd_in.page]; // RL18
					read_valid_out <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// run edges and adc sampling
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			run_prev_r <= '0;
		else
			run_prev_r <= run_in;
	end

	assign run_rise = run_in & ~run_prev_r;
	assign run_cycled = |run_rise;

	// undertemp only moves at adc updates, so response lags by a period
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			ut_seen_r <= '0;
		else if (adc_sample_in)
			ut_seen_r <= ext_ut_in; // RL14
	end

	// ------------------------------------------------------------------
	// die overtemp flag and hold
	// ------------------------------------------------------------------
	// condition present wins over a clear in the same cycle
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			die_flag_r <= 1'b0;
		else
			die_flag_r <= die_ot_in || // RL1
				(die_flag_r && !(clear_faults_in || run_cycled)); // RL6
	end

	// no retry timer: the output simply follows the condition
	assign die_hold = die_ot_in && die_resp_r.resp[1]; // RL4 RL5 RL7

	// ------------------------------------------------------------------
	// per-output sequencers
	// ------------------------------------------------------------------
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			response_channel #(
				.RESTART_CYCLES(RESTART_CYCLES)
			) u_ch (
				.clock_in(clock_in),
				.reset_n_in(reset_n_in),
				.run_in(run_in[c]),
				.run_rise_in(run_rise[c]),
				.clear_in(clear_faults_in),
				.ot_in(ext_ot_in[c]),
				.ut_in(ut_seen_r[c]),
				.ot_resp_in(ext_ot_resp_r[c]),
				.ut_resp_in(ext_ut_resp_r[c]),
				.enable_out(ch_enable[c]),
				.ot_flag_out(ch_ot_flag[c]),
				.ut_flag_out(ch_ut_flag[c])
			);
		end
	endgenerate

	// die hold overrides both outputs
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			out_enable_out <= '0;
		else
			out_enable_out <= ch_enable & {NCH{!die_hold}}; // RL4 RL5
	end

	// ------------------------------------------------------------------
	// status registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			status_byte_out <= 8'h00;
			status_word_hi_out <= 8'h00;
			mfr_status_out <= 8'h00;
		end else begin
			status_byte_out <= 8'h00;
			status_word_hi_out <= 8'h00;
			mfr_status_out <= 8'h00;
			status_byte_out[`SB_NONE_ABOVE] <= die_flag_r; // RL1
			status_byte_out[`SB_CML] <= cml_r;
			status_byte_out[`SB_TEMPERATURE] <= |(ch_ot_flag | ch_ut_flag);
			status_word_hi_out[`SW_MFR] <= die_flag_r; // RL1
			mfr_status_out[`MFR_OT_BIT] <= die_flag_r; // RL1
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			status_temp_out <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				status_temp_out[i] <= 8'h00;
				status_temp_out[i][`ST_OT_FAULT] <= ch_ot_flag[i]; // RL12
				status_temp_out[i][`ST_UT_FAULT] <= ch_ut_flag[i]; // RL13
			end
		end
	end

	// ------------------------------------------------------------------
	// alert: raised by a newly flagged unmasked source
	// ------------------------------------------------------------------
	// a new fault in the clearing cycle keeps the alert low
	assign alert_set = (die_ot_in && !die_flag_r && !alert_mask_in.die_ot) ||
		(|(ext_ot_in & ~ch_ot_flag) && !alert_mask_in.ext_ot) ||
		(|(ut_seen_r & ~ch_ut_flag) && !alert_mask_in.ext_ut);

	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			alert_n_out <= 1'b1;
		else if (alert_set)
			alert_n_out <= 1'b0; // RL2
		else if (clear_faults_in)
			alert_n_out <= 1'b1;
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_die_bad_write;
		die_wr && die_bad;
	endsequence

	sequence s_cml_reported;
		cml_r ##1 status_byte_out[`SB_CML];
	endsequence

	a_die_status_set: assert property ( // RL1
		die_ot_in |-> ##2 (status_byte_out[`SB_NONE_ABOVE] &&
			status_word_hi_out[`SW_MFR] && mfr_status_out[`MFR_OT_BIT]))
		else $error("die overtemp status not set");

	a_alert_unmasked: assert property ( // RL2
		(die_ot_in && !die_flag_r && !alert_mask_in.die_ot) |=> !alert_n_out)
		else $error("alert not raised on die overtemp");

	a_die_code_refused: assert property ( // RL3
		(s_die_bad_write and (wr_byte.resp[1] == 1'b0)) |=>
			(die_resp_r == $past(die_resp_r)) ##0 s_cml_reported)
		else $error("unsupported die response code accepted");

	a_die_output_off: assert property ( // RL4
		(die_ot_in && die_resp_r.resp[1]) |=> (out_enable_out == 2'b00))
		else $error("output not disabled on die overtemp");

	a_die_resume: assert property ( // RL5
		(!die_ot_in && !$past(die_ot_in) && ch_enable[0]) |=>
			out_enable_out[0])
		else $error("output not resumed after die overtemp");

	a_die_flag_clear: assert property ( // RL6
		(die_flag_r && clear_faults_in && !die_ot_in) |=>
			!die_flag_r ##1 !mfr_status_out[`MFR_OT_BIT])
		else $error("die overtemp flag not cleared");

	a_die_retry_refused: assert property ( // RL8
		(s_die_bad_write and (wr_byte.retry != `RETRY_NONE)) |=>
			(die_resp_r.retry == `RETRY_NONE) && cml_r && write_refused_out)
		else $error("die retry code accepted");

	a_die_delay_kept: assert property ( // RL9
		(die_wr && !die_bad) |=> (die_resp_r.resp == $past(wr_byte.resp)) &&
			!cml_r == !$past(cml_r))
		else $error("good die write with any delay not stored");

	a_ext_page_write: assert property ( // RL18
		(ext_ot_wr && !ext_bad && !cmd_in.page) |=>
			(ext_ot_resp_r[0] == $past(wr_byte)) &&
			(ext_ot_resp_r[1] == $past(ext_ot_resp_r[1])))
		else $error("paged overtemp response write misplaced");

	a_ext_ot_status: assert property ( // RL12
		ext_ot_in[0] |-> ##2 (status_temp_out[0][`ST_OT_FAULT] &&
			status_byte_out[`SB_TEMPERATURE]))
		else $error("external overtemp status not set");

	a_ut_adc_sample: assert property ( // RL14
		(adc_sample_in && ext_ut_in[1]) |-> ##3 status_temp_out[1][`ST_UT_FAULT])
		else $error("undertemp not reported after adc update");

	a_read_one_byte: assert property ( // RL15
		(cmd_in.rd && (cmd_in.code == `CMD_EXT_UT_RESP)) |=>
			read_valid_out ##1 !read_valid_out || $past(cmd_in.rd))
		else $error("response read not a single byte");

endmodule : temperature_fault_response

//--- testbench.sv
/*
 * self-checking testbench for the temperature fault-response block.
 * assumes host_model drives the command port; restart count shortened.
 */
`timescale 1ns/10ps
`include "temp_fault_consts.svh"

module testbench;
	import temp_fault_pkg::*;

	localparam int RESTART = 4;
	logic clock_in;
	logic reset_n_in;
	cmd_req_t cmd;
	logic clear;
	logic [1:0] run;
	logic die_ot;
	logic [1:0] ext_ot;
	logic [1:0] ext_ut;
	logic adc;
	alert_mask_t mask;
	logic [7:0] rdata;
	logic rvalid;
	logic refused;
	logic [7:0] sbyte;
	logic [7:0] sword;
	logic [7:0] smfr;
	logic [1:0][7:0] stemp;
	logic alert_n;
	logic [1:0] en;
	int fails;
	int checked;

	temperature_fault_response #(.RESTART_CYCLES(RESTART)) dut (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .cmd_in(cmd),
		.clear_faults_in(clear), .run_in(run), .die_ot_in(die_ot),
		.ext_ot_in(ext_ot), .ext_ut_in(ext_ut), .adc_sample_in(adc),
		.alert_mask_in(mask), .read_data_out(rdata),
		.read_valid_out(rvalid), .write_refused_out(refused),
		.status_byte_out(sbyte), .status_word_hi_out(sword),
		.mfr_status_out(smfr), .status_temp_out(stemp),
		.alert_n_out(alert_n), .out_enable_out(en));

	host_model host (.clock_in(clock_in), .read_data_in(rdata),
		.read_valid_in(rvalid), .write_refused_in(refused),
		.cmd_out(cmd), .clear_out(clear));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic expect_v(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask : expect_v

	task automatic expect_b(input logic got, input logic exp,
		input string what);
		expect_v({7'h0, got}, {7'h0, exp}, what);
	endtask : expect_b

	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : settle

	task automatic put(input logic page, input logic [7:0] code,
		input logic [7:0] data, input logic no);
		logic [7:0] d;
		logic v;
		logic r;
		host.transfer(1'b1, 1'b0, page, code, data, d, v, r);
		expect_b(r, no, "write refusal");
	endtask : put

	task automatic get(input logic page, input logic [7:0] code,
		input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		logic r;
		host.transfer(1'b0, 1'b1, page, code, 8'h00, d, v, r);
		expect_b(v, 1'b1, "read valid");
		expect_v(d, exp, "read data");
	endtask : get

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic check_defaults();
		for (int p = 0; p < 2; p++) begin
			get(p[0], `CMD_EXT_OT_RESP, `EXT_RESP_RESET);
			get(p[0], `CMD_EXT_UT_RESP, `EXT_RESP_RESET);
		end
		get(1'b0, `CMD_DIE_OT_RESP, `DIE_RESP_RESET);
		expect_v(sbyte, 8'h00, "status after reset");
		expect_b(alert_n, 1'b1, "alert idle");
	endtask : check_defaults

	// one page written, the other copy must stay untouched
	task automatic check_paging();
		put(1'b1, `CMD_EXT_OT_RESP, 8'h80, 1'b0);
		get(1'b1, `CMD_EXT_OT_RESP, 8'h80);
		get(1'b0, `CMD_EXT_OT_RESP, `EXT_RESP_RESET);
		put(1'b1, `CMD_EXT_OT_RESP, `EXT_RESP_RESET, 1'b0);
		// and the other way round: page zero written, page one kept
		put(1'b0, `CMD_EXT_OT_RESP, 8'h38, 1'b0);
		get(1'b1, `CMD_EXT_OT_RESP, `EXT_RESP_RESET);
		put(1'b0, `CMD_EXT_OT_RESP, `EXT_RESP_RESET, 1'b0);
	endtask : check_paging

	task automatic check_die_writes();
		for (int c = 0; c < 2; c++) begin
			put(1'b0, `CMD_DIE_OT_RESP, {c[1:0], 6'h00}, 1'b1);
		end
		for (int t = 1; t < 8; t++) begin
			put(1'b0, `CMD_DIE_OT_RESP, {2'h2, t[2:0], 3'h0}, 1'b1);
		end
		get(1'b0, `CMD_DIE_OT_RESP, `DIE_RESP_RESET);
		expect_b(sbyte[`SB_CML], 1'b1, "cml raised");
		put(1'b0, `CMD_EXT_UT_RESP, 8'hc0, 1'b1);
		get(1'b0, `CMD_EXT_UT_RESP, `EXT_RESP_RESET);
		put(1'b0, `CMD_DIE_OT_RESP, 8'h87, 1'b0);
		host.clear_faults();
		settle(2);
		expect_v(sbyte, 8'h00, "cml cleared");
	endtask : check_die_writes

	// a delay field of 7 must not postpone the shutdown
	task automatic check_die_trip();
		@(posedge clock_in) die_ot <= 1'b1;
		settle(3);
		expect_v({6'h0, en}, 8'h00, "outputs off");
		expect_b(alert_n, 1'b0, "alert on die fault");
		expect_b(sbyte[`SB_NONE_ABOVE], 1'b1, "catch-all");
		expect_b(sword[`SW_MFR], 1'b1, "mfr word bit");
		expect_b(smfr[`MFR_OT_BIT], 1'b1, "mfr ot flag");
		host.clear_faults();
		settle(12);
		expect_v({6'h0, en}, 8'h00, "held while hot");
		expect_b(smfr[`MFR_OT_BIT], 1'b1, "flag while hot");
		@(posedge clock_in) die_ot <= 1'b0;
		settle(3);
		expect_v({6'h0, en}, 8'h03, "resumed");
		expect_b(smfr[`MFR_OT_BIT], 1'b1, "flag latched");
		// clear-faults drops a latched flag once the die has cooled
		host.clear_faults();
		settle(2);
		expect_b(smfr[`MFR_OT_BIT], 1'b0, "clear clears");
		@(posedge clock_in) die_ot <= 1'b1;
		@(posedge clock_in) die_ot <= 1'b0;
		settle(3);
		expect_b(smfr[`MFR_OT_BIT], 1'b1, "flag set again");
		expect_b(alert_n, 1'b0, "alert on new die fault");
		@(posedge clock_in) run <= 2'b10;
		settle(2);
		@(posedge clock_in) run <= 2'b11;
		settle(4);
		expect_b(smfr[`MFR_OT_BIT], 1'b0, "run cycle clears");
	endtask : check_die_trip

	task automatic check_ext_over();
		int n;
		host.clear_faults();
		settle(2);
		expect_b(alert_n, 1'b1, "alert released");
		@(posedge clock_in) ext_ot <= 2'b01;
		settle(3);
		expect_b(en[0], 1'b0, "ext trip");
		expect_b(en[1], 1'b1, "other output runs");
		expect_b(sbyte[`SB_TEMPERATURE], 1'b1, "temperature bit");
		expect_b(stemp[0][`ST_OT_FAULT], 1'b1, "ot flag");
		expect_b(alert_n, 1'b0, "alert on ext ot");
		@(posedge clock_in) ext_ot <= 2'b00;
		n = 0;
		while (en[0] !== 1'b1 && n < 3 * RESTART + 4) begin
			settle(1);
			n++;
		end
		expect_b(en[0], 1'b1, "restarted");
		// masked source still flags but leaves the alert alone
		host.clear_faults();
		@(posedge clock_in) mask.ext_ot <= 1'b1;
		settle(2);
		@(posedge clock_in) ext_ot <= 2'b10;
		settle(3);
		expect_b(stemp[1][`ST_OT_FAULT], 1'b1, "masked flag");
		expect_b(alert_n, 1'b1, "masked alert");
		@(posedge clock_in) ext_ot <= 2'b00;
		settle(3 * RESTART);
		@(posedge clock_in) mask.ext_ot <= 1'b0;
	endtask : check_ext_over

	// undertemp is seen only when a conversion completes
	task automatic check_ext_under();
		put(1'b1, `CMD_EXT_UT_RESP, 8'h38, 1'b0);
		host.clear_faults();
		@(posedge clock_in) ext_ut <= 2'b10;
		settle(6);
		expect_b(stemp[1][`ST_UT_FAULT], 1'b0, "before sample");
		@(posedge clock_in) adc <= 1'b1;
		@(posedge clock_in) adc <= 1'b0;
		settle(3);
		expect_b(stemp[1][`ST_UT_FAULT], 1'b1, "ut flag");
		expect_b(sbyte[`SB_TEMPERATURE], 1'b1, "temperature bit");
		expect_v({6'h0, en}, 8'h03, "keeps running");
		expect_b(alert_n, 1'b0, "alert on ut");
		@(posedge clock_in) ext_ut <= 2'b00;
	endtask : check_ext_under

	// ------------------------------------------------------------------
	// run control
	// ------------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// the whole run takes some 160 cycles
	initial begin
		repeat (4000) @(posedge clock_in);
		fails++;
		conclude();
	end

	initial begin
		fails = 0;
		checked = 0;
		reset_n_in = 1'b0;
		run = 2'b11;
		die_ot = 1'b0;
		ext_ot = 2'b00;
		ext_ut = 2'b00;
		adc = 1'b0;
		mask = '0;
		repeat (12) @(posedge clock_in);
		reset_n_in <= 1'b1;
		settle(2);
		check_defaults();
		check_paging();
		check_die_writes();
		check_die_trip();
		check_ext_over();
		check_ext_under();
		conclude();
	end

endmodule : testbench
